// ### bench/vsf_status_features_chk.sv
`timescale 1ns/1ps
// ****************************************************************
// Status and feature port checker
// ****************************************************************
module vsf_status_features_chk
(
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       sys_rst,
  // Register port
  input wire logic [vsf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  // Device core side
  input wire logic                       dev_error,
  input wire logic                       used_notify_req,
  input wire logic                       used_notify,
  input wire logic                       queue_run,
  input wire logic                       cfg_change_notify,
  input wire logic                       dev_reset_pulse,
  input wire logic [7:0]                 status_out
);
  logic st_zero;
  logic st_rdy_wr;
  // The design takes any status write whose low byte is zero as the device reset
  assign st_zero   = reg_wr && reg_addr == vsf_pkg::REG_STATUS && reg_wdata[7:0] == 8'h00;
  assign st_rdy_wr = reg_wr && reg_addr == vsf_pkg::REG_STATUS && reg_wdata[vsf_pkg::ST_DRV_READY];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_reset_clears: assert property ($past(sys_rst) |-> status_out == 8'h00 && !queue_run)
    else $error("status not zero after reset");
  a_drv_reset: assert property (st_zero |=> dev_reset_pulse && status_out[3:0] == 4'h0)
    else $error("status write of zero did not reset");
  a_queue_gate: assert property ($rose(queue_run) |-> $past(st_rdy_wr))
    else $error("queue activity started without a ready write");
  a_used_gate: assert property (used_notify == (used_notify_req && status_out[2]))
    else $error("used notification not gated by ready bit");
  a_error_sets: assert property (dev_error && !status_out[6] |=> status_out[6])
    else $error("error did not set needs reset");
  a_error_notify: assert property (dev_error && !status_out[6] && status_out[2] && !st_zero
    |=> cfg_change_notify)
    else $error("config change notification missing");
  a_notify_cause: assert property (cfg_change_notify
    |-> status_out[6] && !$past(status_out[6]) && status_out[2])
    else $error("config change notification without cause");
  a_bits_sticky: assert property (!st_zero |=> (status_out & $past(status_out)) == $past(status_out))
    else $error("status bit lost without reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule
bind vsf_status_features vsf_status_features_chk chk_u
(
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_error(dev_error), .used_notify_req(used_notify_req),
  .used_notify(used_notify), .queue_run(queue_run), .cfg_change_notify(cfg_change_notify),
  .dev_reset_pulse(dev_reset_pulse), .status_out(status_out)
);

// ### bench/vsf_status_features_test.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module vsf_status_features_test;
  // Position 41 and 44 are reserved and must never be offered
  localparam logic [127:0] DEV = 128'h00000000_00000001_00040200_00000003;
  localparam logic [127:0] XP  = 128'h00000000_00000000_00001001_00000000;
  localparam logic [127:0] OFF = 128'h00000000_00000001_00040001_00000023;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, dev_error, used_notify_req, rnd_on, rd_d;
  logic        used_notify, queue_run, cfg_change_notify, dev_reset_pulse;
  logic [7:0]  reg_addr, status_out;
  logic [31:0] reg_wdata, reg_rdata, rnd;
  logic [31:0] exp_q[$];
  int          err_total, samples_checked;

  vsf_status_features #(.DEV_FEATURES(DEV), .XPORT_FEATURES(XP), .CFG_EXT_LEN(4), .CFG_EXT_BIT(5)) dut_u
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_error(dev_error), .used_notify_req(used_notify_req),
    .used_notify(used_notify), .queue_run(queue_run), .cfg_change_notify(cfg_change_notify),
    .dev_reset_pulse(dev_reset_pulse), .status_out(status_out)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
  endtask

  task automatic err_pulse;
    @(posedge clk_sys);
    dev_error <= 1'b1;
    @(posedge clk_sys);
    dev_error <= 1'b0;
    #1;
  endtask

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Read answers are compared in the cycle after the strobe
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys)
    if (rd_d === 1'b1)
      chk(reg_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdeadbeef);

  always @(posedge clk_sys) used_notify_req <= rnd_on ? 1'($urandom) : 1'b0;

  initial
  begin
    {reg_wr, reg_rd, dev_error, rnd_on} = 4'h0;
    {reg_addr, reg_wdata} = 40'h0;
    err_total = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rnd = $urandom(32'ha988f643);
    rnd_on <= 1'b1;
    rd(vsf_pkg::REG_STATUS, 32'h0);
    rd(8'h20, 32'h0);
    rd(vsf_pkg::REG_INFO, 32'h6);
    for (int k = 0; k < 6; k++)
    begin
      wr(vsf_pkg::REG_FEAT_SEL, 32'(k));
      rd(vsf_pkg::REG_DEV_FEAT, (k < 4) ? OFF[32*k+:32] : 32'h0);
    end
    $display("offer test done");
    wr(vsf_pkg::REG_STATUS, 32'h1);
    chk(32'(status_out), 32'h1);
    wr(vsf_pkg::REG_STATUS, 32'h2);
    chk(32'(status_out), 32'h3);
    wr(vsf_pkg::REG_FEAT_SEL, 32'h0);
    wr(vsf_pkg::REG_DRV_FEAT, 32'h33);
    rd(vsf_pkg::REG_INFO, 32'h4);
    wr(vsf_pkg::REG_STATUS, 32'h8);
    chk(32'(status_out), 32'h3);
    wr(vsf_pkg::REG_DRV_FEAT, 32'h23);
    wr(vsf_pkg::REG_FEAT_SEL, 32'h1);
    rnd = $urandom & OFF[63:32];
    wr(vsf_pkg::REG_DRV_FEAT, rnd);
    rd(vsf_pkg::REG_INFO, 32'h6);
    wr(vsf_pkg::REG_STATUS, 32'h8);
    chk(32'(status_out), 32'hb);
    wr(vsf_pkg::REG_DRV_FEAT, ~rnd);
    rd(vsf_pkg::REG_DRV_FEAT, rnd);
    chk(32'(queue_run), 32'h0);
    chk(32'(used_notify), 32'h0);
    wr(vsf_pkg::REG_STATUS, 32'h4);
    chk(32'({queue_run, status_out}), 32'h10f);
    chk(32'(used_notify), 32'(used_notify_req));
    rd(vsf_pkg::REG_INFO, 32'h7);
    wr(vsf_pkg::REG_STATUS, 32'h70);
    chk(32'(status_out), 32'hf);
    $display("negotiation test done");
    err_pulse();
    chk(32'({cfg_change_notify, status_out}), 32'h14f);
    rd(vsf_pkg::REG_CFG_GEN, 32'h1);
    err_pulse();
    chk(32'(cfg_change_notify), 32'h0);
    rd(vsf_pkg::REG_CFG_GEN, 32'h1);
    wr(vsf_pkg::REG_STATUS, 32'h0);
    chk(32'({dev_reset_pulse, status_out}), 32'h100);
    rd(vsf_pkg::REG_DRV_FEAT, 32'h0);
    err_pulse();
    chk(32'({cfg_change_notify, status_out}), 32'h40);
    rd(vsf_pkg::REG_CFG_GEN, 32'h2);
    wr(vsf_pkg::REG_STATUS, 32'h80);
    chk(32'(status_out), 32'hc0);
    wr(vsf_pkg::REG_STATUS, 32'h0);
    wr(vsf_pkg::REG_STATUS, 32'h1);
    chk(32'(status_out), 32'h1);
    $display("error test done");
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk(32'(status_out), 32'h0);
    rd(vsf_pkg::REG_FEAT_SEL, 32'h0);
    rd(vsf_pkg::REG_CFG_GEN, 32'h0);
    repeat (3) @(posedge clk_sys);
    $display("reset test done");
    results();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    results();
  end
endmodule

// ### verilog/vsf_feat_if.sv
`timescale 1ns/1ps
interface vsf_feat_if;
  logic        wr_en;
  logic [1:0]  idx;
  logic [31:0] wr_data;
  logic        clear;
  logic [31:0] rd_data;
  logic        accept_ok;

  modport ctrl
  (
    output wr_en,
    output idx,
    output wr_data,
    output clear,
    input  rd_data,
    input  accept_ok
  );

  modport store
  (
    input  wr_en,
    input  idx,
    input  wr_data,
    input  clear,
    output rd_data,
    output accept_ok
  );
endinterface

// ### verilog/vsf_feat_store.sv
`timescale 1ns/1ps
module vsf_feat_store #(
  parameter logic [127:0] OFFERED = 128'h0
)
(
  // Clock and reset
  input wire logic    clk_sys,
  input wire logic    sys_rst,
  // Controller side
  vsf_feat_if.store   fif
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [vsf_pkg::FEAT_WORDS-1:0][31:0] words;
    logic [vsf_pkg::FEAT_WORDS-1:0]       ok;
    logic [31:0]                          rd_data;
  } vsf_store_s;

  vsf_store_s                     st;
  vsf_store_s                     next_st;
  logic [vsf_pkg::FEAT_WORDS-1:0] word_ok;

  // A word is acceptable when it holds no bit the device did not offer
  genvar gi;
  generate
    for (gi = 0; gi < vsf_pkg::FEAT_WORDS; gi++)
    begin : g_word
      assign word_ok[gi] = ((fif.wr_data & ~OFFERED[gi*32 +: 32]) == 32'h0);
    end
  endgenerate

  always_comb
  begin
    next_st         = st;
    next_st.rd_data = st.words[fif.idx];
    if (fif.clear)
    begin
      next_st.words = '0;
      next_st.ok    = '1;
    end
    else if (fif.wr_en)
    begin
      next_st.words[fif.idx] = fif.wr_data;
      next_st.ok[fif.idx]    = word_ok[fif.idx];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st.words   <= '0;
      st.ok      <= '1;
      st.rd_data <= 32'h0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign fif.rd_data   = st.rd_data;
  assign fif.accept_ok = &st.ok;

endmodule

// ### verilog/vsf_pkg.sv
package vsf_pkg;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  REG_STATUS   = 8'h00;
  localparam logic [7:0]  REG_FEAT_SEL = 8'h04;
  localparam logic [7:0]  REG_DEV_FEAT = 8'h08;
  localparam logic [7:0]  REG_DRV_FEAT = 8'h0c;
  localparam logic [7:0]  REG_CFG_GEN  = 8'h10;
  localparam logic [7:0]  REG_INFO     = 8'h14;

  // ****************************************************************
  // Status field layout
  // ****************************************************************
  localparam int          ST_GUEST_FOUND  = 0;
  localparam int          ST_SW_CAPABLE   = 1;
  localparam int          ST_DRV_READY    = 2;
  localparam int          ST_NEG_DONE     = 3;
  localparam int          ST_NEEDS_RESET  = 6;
  localparam int          ST_GAVE_UP      = 7;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [7:0]  STATUS_DRV_MASK = 8'h8f;

  // Packed from the most significant bit downward, no padding
  typedef struct packed {
    logic       guest_gave_up_bit;
    logic       needs_reset;
    logic [1:0] rsvd;
    logic       neg_done;
    logic       drv_ready;
    logic       sw_capable;
    logic       guest_found_device;
  } vsf_status_s;

  // ****************************************************************
  // Feature bit ranges
  // ****************************************************************
  localparam int             FEAT_WORDS   = 4;
  localparam int             FEAT_BITS    = 128;
  localparam logic [127:0]   DEVTYPE_MASK = 128'hffffffff_ffffffff_fffc0000_00ffffff;
  localparam logic [127:0]   XPORT_MASK   = 128'h00000000_00000000_000001ff_ff000000;
  localparam logic [127:0]   RESV_MASK    = 128'h00000000_00000000_0003fe00_00000000;

  // ****************************************************************
  // Info register bits
  // ****************************************************************
  localparam int INFO_QUEUE_RUN = 0;
  localparam int INFO_ACCEPT_OK = 1;
  localparam int INFO_CFG_EXT   = 2;

endpackage

// ### verilog/vsf_status_features.sv
// Overview of operation
// - Status is zero from power-up and after every device reset; an error in the same cycle as the reset write sets needs-reset if it was clear.
// - Status bit value 1 means the guest found a valid device.
// - Status bit value 2 means guest software can drive it; may come late.
// - Status bit value 4 means the driver is set up and ready.
// - Status bit value 8 means feature negotiation is complete.
// - Status bit value 64 means unrecoverable device error, reset needed.
// - Status bit value 128 means the guest gave up on the device.
// - No buffer consumption or used notification before driver-ready.
// - Device sets needs-reset on entering an error needing reset.
// - Needs-reset raised while driver-ready set emits a config change notification.
// - Device shows all supported features; driver writes back its accepted subset.
// - Accepted features change only by device reset and new negotiation.
// - Positions 0 to 23 and 50 to 127 are device-type features.
// - Positions 24 to 40 are for queue and negotiation extensions.
// - Positions 41 to 49 and 128 upward are reserved, never offered.
// - Extra configuration fields are announced by offering a feature bit.
// - Little-endian fields store low byte first, big-endian high byte first.
// - Bit-fields pack from the least significant bit in listed order.
// - Shared structures have no padding between or after members.
// - Negotiation-complete is not latched when the feature subset is unacceptable.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module vsf_status_features #(
  parameter logic [127:0] DEV_FEATURES   = 128'h0,
  parameter logic [127:0] XPORT_FEATURES = 128'h0,
  parameter int           CFG_EXT_LEN    = 0,
  parameter int           CFG_EXT_BIT    = 0
)
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  // Register port
  input  wire logic [vsf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  // Device core side
  input  wire logic                       dev_error,
  input  wire logic                       used_notify_req,
  output logic                            used_notify,
  output logic                            queue_run,
  output logic                            cfg_change_notify,
  output logic                            dev_reset_pulse,
  output logic      [7:0]                 status_out
);

  // ****************************************************************
  // Offered feature set
  // ****************************************************************
  localparam logic [127:0] EXT_BIT_MASK = (CFG_EXT_LEN > 0) ? (128'h1 << CFG_EXT_BIT) : 128'h0;
  // Device-type bits only in their ranges, extension bits only in theirs, reserved never
  localparam logic [127:0] OFFERED      = (((DEV_FEATURES | EXT_BIT_MASK) & vsf_pkg::DEVTYPE_MASK)
                                          | (XPORT_FEATURES & vsf_pkg::XPORT_MASK))
                                          & ~vsf_pkg::RESV_MASK;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    vsf_pkg::vsf_status_s status;
    logic [31:0]          feat_sel;
    logic [7:0]           cfg_gen;
    logic [31:0]          rdata;
    logic                 rd_feat_drv;
    logic                 cfg_notify;
    logic                 dev_reset;
  } vsf_state_s;

  vsf_state_s  st;
  vsf_state_s  next_st;
  vsf_feat_if  fif ();
  logic        sel_in_range;
  logic [7:0]  wr_bits;
  logic        feat_wr;
  logic        feat_clear;

  vsf_feat_store #(
    .OFFERED (OFFERED)
  ) u_store (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .fif     (fif)
  );

  // Selector values of four and above address positions 128 and upward
  assign sel_in_range = (st.feat_sel[31:2] == 30'h0);

  // ****************************************************************
  // Register access and status update
  // ****************************************************************
  always_comb
  begin
    next_st             = st;
    next_st.rdata       = 32'h0;
    next_st.rd_feat_drv = 1'b0;
    next_st.cfg_notify  = 1'b0;
    next_st.dev_reset   = 1'b0;
    wr_bits             = reg_wdata[7:0] & vsf_pkg::STATUS_DRV_MASK;
    feat_wr             = 1'b0;
    feat_clear          = 1'b0;
    if (!fif.accept_ok)
    begin
      wr_bits[vsf_pkg::ST_NEG_DONE] = 1'b0;
    end
    if (reg_wr)
    begin
      unique case (reg_addr)
        vsf_pkg::REG_STATUS:
        begin
          if (reg_wdata[7:0] == 8'h00)
          begin
            // Writing zero is the device reset
            next_st.status    = vsf_pkg::vsf_status_s'(vsf_pkg::STATUS_RESET);
            next_st.dev_reset = 1'b1;
            feat_clear        = 1'b1;
          end
          else
          begin
            // Bits only accumulate; a zero in the write clears nothing
            next_st.status = vsf_pkg::vsf_status_s'(st.status | wr_bits);
          end
        end
        vsf_pkg::REG_FEAT_SEL:
        begin
          next_st.feat_sel = reg_wdata;
        end
        vsf_pkg::REG_DRV_FEAT:
        begin
          // Frozen once negotiation has completed
          feat_wr = sel_in_range && !st.status.neg_done;
        end
        default:
        begin
        end
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        vsf_pkg::REG_STATUS:
        begin
          next_st.rdata = {24'h0, st.status};
        end
        vsf_pkg::REG_FEAT_SEL:
        begin
          next_st.rdata = st.feat_sel;
        end
        vsf_pkg::REG_DEV_FEAT:
        begin
          // Lowest feature position sits in the least significant bit
          next_st.rdata = sel_in_range ? OFFERED[st.feat_sel[1:0]*32 +: 32] : 32'h0;
        end
        vsf_pkg::REG_DRV_FEAT:
        begin
          next_st.rd_feat_drv = sel_in_range;
        end
        vsf_pkg::REG_CFG_GEN:
        begin
          next_st.rdata = {24'h0, st.cfg_gen};
        end
        vsf_pkg::REG_INFO:
        begin
          next_st.rdata[vsf_pkg::INFO_QUEUE_RUN] = st.status.drv_ready;
          next_st.rdata[vsf_pkg::INFO_ACCEPT_OK] = fif.accept_ok;
          next_st.rdata[vsf_pkg::INFO_CFG_EXT]   = (CFG_EXT_LEN > 0);
        end
        default:
        begin
        end
      endcase
    end
    // Error set comes last so it wins over a reset written in the same cycle
    if (dev_error && !st.status.needs_reset)
    begin
      next_st.status.needs_reset = 1'b1;
      next_st.cfg_gen            = st.cfg_gen + 8'h01;
      next_st.cfg_notify         = next_st.status.drv_ready;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st.status      <= vsf_pkg::vsf_status_s'(vsf_pkg::STATUS_RESET);
      st.feat_sel    <= 32'h0;
      st.cfg_gen     <= 8'h00;
      st.rdata       <= 32'h0;
      st.rd_feat_drv <= 1'b0;
      st.cfg_notify  <= 1'b0;
      st.dev_reset   <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Feature store connection
  // ****************************************************************
  assign fif.wr_en   = feat_wr;
  assign fif.idx     = st.feat_sel[1:0];
  assign fif.wr_data = reg_wdata;
  assign fif.clear   = feat_clear;

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata         = st.rd_feat_drv ? fif.rd_data : st.rdata;
  assign queue_run         = st.status.drv_ready;
  assign used_notify       = used_notify_req && st.status.drv_ready;
  assign cfg_change_notify = st.cfg_notify;
  assign dev_reset_pulse   = st.dev_reset;
  assign status_out        = st.status;

endmodule
